// File: iprm_pkg.sv
package iprm_pkg;
   // ------------------------------------------------------------
   // Command codes on the command port
   // ------------------------------------------------------------
   localparam logic [3:0] CMD_NONE = 4'h0;
   localparam logic [3:0] CMD_NS_DONE = 4'h1;       // Non-specific service done
   localparam logic [3:0] CMD_SP_DONE = 4'h2;       // Specific service done
   localparam logic [3:0] CMD_ROT_NS_DONE = 4'h3;   // Rotate on non-specific done
   localparam logic [3:0] CMD_ROT_SP_DONE = 4'h4;   // Rotate on specific done
   localparam logic [3:0] CMD_SET_PRIO = 4'h5;      // Set lowest priority
   localparam logic [3:0] CMD_ROT_AUTO_SET = 4'h6;
   localparam logic [3:0] CMD_ROT_AUTO_CLR = 4'h7;
   localparam logic [3:0] CMD_SMM_SET = 4'h8;
   localparam logic [3:0] CMD_SMM_CLR = 4'h9;
   localparam logic [3:0] CMD_AUTO_SET = 4'ha;
   localparam logic [3:0] CMD_AUTO_CLR = 4'hb;

   // ------------------------------------------------------------
   // Reset values and the default acknowledge level
   // ------------------------------------------------------------
   localparam logic [2:0] LOWEST_RESET = 3'h7;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [2:0] DEFAULT_LEVEL = 3'h7;

   // Command carried from host
   typedef struct packed {
      logic [3:0] code;
      logic [2:0] level;
   } iprm_cmd_s;

   // Acknowledge answer
   typedef struct packed {
      logic is_default;
      logic [2:0] level;
   } iprm_ack_s;

   typedef enum logic [2:0] {
      ACK_IDLE = 3'b001,
      ACK_FIRST = 3'b010,
      ACK_SECOND = 3'b100
   } iprm_ack_e;
endpackage

// File: iprm_resolve.sv
`timescale 1ns/1ps
module iprm_resolve (
   input wire logic [7:0] bits,        // Candidate bits
   input wire logic [2:0] lowest,      // Lowest priority level
   output logic found,                 // Any bit set
   output logic [2:0] level            // Highest priority set level
);
   logic [2:0] cand;
   logic [2:0] prio;
   logic [2:0] best;

   // ------------------------------------------------------------
   // Scan all eight bits; lowest+1 ranks highest around the ring
   // ------------------------------------------------------------
   always_comb begin
      found = 1'b0;
      level = 3'h0;
      cand = 3'h0;
      prio = 3'h0;
      best = 3'h7;
      for (int i = 0; i < 8; i++) begin
         cand = 3'(i);
         prio = 3'(cand - lowest + 3'h7);
         if (bits[i] && (!found || prio < best)) begin
            found = 1'b1;
            best = prio;
            level = cand;
         end
      end
   end
endmodule

// File: iprm_bank.sv
`timescale 1ns/1ps
// Contract
// - Serviced level becomes lowest in automatic rotation
// - Rotate non-specific done clears highest, rotates
// - Next higher level wraps to highest
// - Rotating auto mode rotates after second acknowledge
// - Separate set and clear rotate-auto commands
// - Set priority makes named level lowest
// - Rotate specific done clears and lowers named
// - Specific rotation accepted at any time
// - Nested default; non-specific done keeps order
// - Eight-bit mask, bit n disables channel n
// - Mask gates latch output only
// - Unmasking active request raises interrupt
// - Vanished request yields default level seven
// - Lower levels than in-service are inhibited
// - Special mask allows all except in-service
// - Special mask holds until disabled
// - Acknowledge sets in-service of highest pending
// - Auto mode ends the acknowledged level at the second acknowledge
// - Reset enters nested, level zero highest
module iprm_bank (
   input wire logic sys_clk,                   // System clock
   input wire logic reset,                     // Synchronous reset, high
   input wire logic [7:0] request_in,          // Request level, high active
   input wire logic cmd_valid,                 // Command strobe
   input wire iprm_pkg::iprm_cmd_s cmd,        // Command code and level
   input wire logic mask_write,                // Mask write strobe
   input wire logic [7:0] mask_wdata,          // Mask write data
   input wire logic irq_acknowledge_cycle,     // Acknowledge cycle strobe
   output logic [7:0] channel_mask,            // Mask register
   output logic [7:0] request_latch,           // Request latch
   output logic [7:0] in_service_bits,         // In-service register
   output logic [2:0] lowest_level,            // Lowest priority pointer
   output logic special_mask,                  // Special mask mode flag
   output logic auto_service_done,             // Auto service done flag
   output logic rotate_auto,                   // Rotating auto flag
   output logic int_req,                       // Interrupt request to host
   output iprm_pkg::iprm_ack_s ack_data        // Acknowledged level
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic [7:0] mask_reg, mask_next;
   logic [7:0] irr_reg, irr_next;
   logic [7:0] isr_reg, isr_next;
   logic [2:0] low_reg, low_next;
   logic smm_reg, smm_next;
   logic auto_service_done_reg, auto_service_done_next;
   logic raeoi_reg, raeoi_next;
   iprm_pkg::iprm_ack_s ack_reg, ack_next;
   iprm_pkg::iprm_ack_e st_reg, st_next;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire logic [3:0] code = cmd_valid ? cmd.code : iprm_pkg::CMD_NONE;
   wire logic do_ns = code == iprm_pkg::CMD_NS_DONE;
   wire logic do_sp = code == iprm_pkg::CMD_SP_DONE;
   wire logic do_rns = code == iprm_pkg::CMD_ROT_NS_DONE;
   wire logic do_rsp = code == iprm_pkg::CMD_ROT_SP_DONE;
   wire logic do_setp = code == iprm_pkg::CMD_SET_PRIO;
   wire logic [7:0] named = 8'h01 << cmd.level;

   // Mode commands, one wire each; codes are exclusive
   wire logic do_smm_on = code == iprm_pkg::CMD_SMM_SET;
   wire logic do_smm_off = code == iprm_pkg::CMD_SMM_CLR;
   wire logic do_rauto_on = code == iprm_pkg::CMD_ROT_AUTO_SET;
   wire logic do_rauto_off = code == iprm_pkg::CMD_ROT_AUTO_CLR;
   wire logic do_auto_on = code == iprm_pkg::CMD_AUTO_SET;
   wire logic do_auto_off = code == iprm_pkg::CMD_AUTO_CLR;

   // Mask gates the latch output only; latch itself keeps requests
   wire logic [7:0] pend = irr_reg & ~mask_reg;

   // ------------------------------------------------------------
   // Priority resolvers: pending requests and in-service bits
   // ------------------------------------------------------------
   logic pend_found;
   logic [2:0] pend_lvl;
   logic isr_found;
   logic [2:0] isr_lvl;
   logic isv_found;
   logic [2:0] isv_lvl;

   iprm_resolve u_pend (
      .bits(pend),
      .lowest(low_reg),
      .found(pend_found),
      .level(pend_lvl)
   );

   // Highest in-service bit, used by non-specific done
   iprm_resolve u_isr (
      .bits(isr_reg),
      .lowest(low_reg),
      .found(isr_found),
      .level(isr_lvl)
   );

   // In special mask the masked in-service bits drop out of the
   // blocking set, but there grant uses smm_ok and not nest_ok
   wire logic [7:0] block_bits = smm_reg ? (isr_reg & ~mask_reg) : isr_reg;
   iprm_resolve u_blk (
      .bits(block_bits),
      .lowest(low_reg),
      .found(isv_found),
      .level(isv_lvl)
   );

   // Effective priorities of winner and blocker
   wire logic [2:0] pend_prio = 3'(pend_lvl - low_reg + 3'h7);
   wire logic [2:0] blk_prio = 3'(isv_lvl - low_reg + 3'h7);
   // Same or lower priority than in-service is inhibited
   wire logic nest_ok = !isv_found || (pend_prio < blk_prio);
   // In special mask only the in-service level itself is refused
   wire logic smm_ok = !isr_reg[pend_lvl];
   wire logic grant = pend_found && (smm_reg ? smm_ok : nest_ok);

   // ------------------------------------------------------------
   // Acknowledge sequence: two strobes per interrupt
   // ------------------------------------------------------------
   wire logic first_ack = irq_acknowledge_cycle && st_reg != iprm_pkg::ACK_FIRST;
   wire logic second_ack = irq_acknowledge_cycle && st_reg == iprm_pkg::ACK_FIRST;

   // ------------------------------------------------------------
   // Events of this cycle, each but point_named with its one-hot bit
   // ------------------------------------------------------------
   // Winner taken in service at the first acknowledge
   wire logic take_req = first_ack && grant;
   wire logic [7:0] grant_bit = 8'h01 << pend_lvl;
   // Automatic end needs a real level; a default answer ends nothing
   wire logic auto_end = second_ack && !ack_reg.is_default && (auto_service_done_reg || raeoi_reg);
   wire logic [7:0] auto_bit = 8'h01 << ack_reg.level;
   // Host ends the top routine; nothing happens with none in service
   wire logic clr_top = (do_ns || do_rns) && isr_found;
   wire logic [7:0] top_bit = 8'h01 << isr_lvl;
   // Host ends a named routine; no state check, so legal at any time
   wire logic clr_named = do_sp || do_rsp;
   // Any command that moves the lowest-priority pointer to cmd.level
   wire logic point_named = do_rsp || do_setp;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         // Waiting for the first strobe of a pair
         iprm_pkg::ACK_IDLE: begin
            if (irq_acknowledge_cycle) begin
               st_next = iprm_pkg::ACK_FIRST;
            end
         end
         // Answer loaded; the next strobe closes the pair
         iprm_pkg::ACK_FIRST: begin
            if (irq_acknowledge_cycle) begin
               st_next = iprm_pkg::ACK_SECOND;
            end
         end
         // A strobe straight away opens the next pair
         iprm_pkg::ACK_SECOND: begin
            st_next = irq_acknowledge_cycle ? iprm_pkg::ACK_FIRST : iprm_pkg::ACK_IDLE;
         end
         default: begin
            st_next = iprm_pkg::ACK_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Request latch: level sampled, cleared when taken in service
   // ------------------------------------------------------------
   always_comb begin
      irr_next = request_in;
      // Taken level drops for one cycle; a held line pends again
      if (take_req) begin
         irr_next = request_in & ~grant_bit;
      end
   end

   // ------------------------------------------------------------
   // Acknowledge answer; a vanished request gives the default level
   // ------------------------------------------------------------
   always_comb begin
      ack_next = ack_reg;
      if (first_ack) begin
         if (grant) begin
            ack_next.is_default = 1'b0;
            ack_next.level = pend_lvl;
         end else begin
            ack_next.is_default = 1'b1;
            ack_next.level = iprm_pkg::DEFAULT_LEVEL;
         end
      end
   end

   // ------------------------------------------------------------
   // In-service bits and rotation pointer
   // ------------------------------------------------------------
   always_comb begin
      isr_next = isr_reg;
      low_next = low_reg;
      // Automatic end at the second acknowledge
      if (auto_end) begin
         isr_next = isr_next & ~auto_bit;
      end
      // Rotating form also lowers the level just served
      if (auto_end && raeoi_reg) begin
         low_next = ack_reg.level;
      end
      // Host commands after the automatic end, so a command wins
      if (clr_top) begin
         isr_next = isr_next & ~top_bit;
      end
      if (do_rns && isr_found) begin
         low_next = isr_lvl;
      end
      if (clr_named) begin
         isr_next = isr_next & ~named;
      end
      if (point_named) begin
         low_next = cmd.level;
      end
      // Setting last: a level taken this cycle outlives any clear
      if (take_req) begin
         isr_next = isr_next | grant_bit;
      end
   end

   // ------------------------------------------------------------
   // Mode flags: each set only by its command, cleared by its pair
   // ------------------------------------------------------------
   always_comb begin
      smm_next = smm_reg;
      auto_service_done_next = auto_service_done_reg;
      raeoi_next = raeoi_reg;
      if (do_smm_on) begin
         smm_next = 1'b1;
      end
      if (do_smm_off) begin
         smm_next = 1'b0;
      end
      // Rotating form: no host command needed once set
      if (do_rauto_on) begin
         raeoi_next = 1'b1;
      end
      if (do_rauto_off) begin
         raeoi_next = 1'b0;
      end
      if (do_auto_on) begin
         auto_service_done_next = 1'b1;
      end
      if (do_auto_off) begin
         auto_service_done_next = 1'b0;
      end
   end

   assign mask_next = mask_write ? mask_wdata : mask_reg;

   // ------------------------------------------------------------
   // Registers; reset gives nested order, level 7 lowest
   // ------------------------------------------------------------
   // Mask register, cleared so every channel starts enabled
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         mask_reg <= iprm_pkg::MASK_RESET;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // Request latch, empty until the first sampled edge
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         irr_reg <= 8'h00;
      end else begin
         irr_reg <= irr_next;
      end
   end

   // Priority pointer and in-service bits of this bank only
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         low_reg <= iprm_pkg::LOWEST_RESET;
         isr_reg <= 8'h00;
      end else begin
         low_reg <= low_next;
         isr_reg <= isr_next;
      end
   end

   // Mode flags; every mode off after reset
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         smm_reg <= 1'b0;
         auto_service_done_reg <= 1'b0;
         raeoi_reg <= 1'b0;
      end else begin
         smm_reg <= smm_next;
         auto_service_done_reg <= auto_service_done_next;
         raeoi_reg <= raeoi_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ack_reg <= '0;
         st_reg <= iprm_pkg::ACK_IDLE;
      end else begin
         ack_reg <= ack_next;
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs; int_req is combinational so unmasking shows at once
   // ------------------------------------------------------------
   assign int_req = grant;

   // Register contents, straight from the flip-flops
   assign channel_mask = mask_reg;
   assign request_latch = irr_reg;
   assign in_service_bits = isr_reg;
   assign lowest_level = low_reg;

   // Mode flags and the last acknowledge answer
   assign special_mask = smm_reg;
   assign auto_service_done = auto_service_done_reg;
   assign rotate_auto = raeoi_reg;
   assign ack_data = ack_reg;
endmodule

// File: iprm_bank_properties.sv
`timescale 1ns/1ps
module iprm_bank_properties (
   input wire logic sys_clk,                // Clock
   input wire logic reset,                  // Sync reset
   input wire logic [7:0] request_in,       // Requests
   input wire logic cmd_valid,              // Command strobe
   input wire iprm_pkg::iprm_cmd_s cmd,     // Command
   input wire logic mask_write,             // Mask strobe
   input wire logic [7:0] mask_wdata,       // Mask data
   input wire logic irq_acknowledge_cycle,  // Ack strobe
   input wire logic [7:0] channel_mask,     // Mask register
   input wire logic [7:0] request_latch,    // Latch
   input wire logic [7:0] in_service_bits,  // In service
   input wire logic [2:0] lowest_level,     // Lowest pointer
   input wire logic special_mask,           // Special mask flag
   input wire logic int_req                 // Host request
);
   // ------------------------------------------------------------
   // Checks on the single clock
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Command alone; an ack end in the same cycle would move the pointer
   sequence cmd_is(logic [3:0] c);
      cmd_valid && cmd.code == c && !irq_acknowledge_cycle;
   endsequence
   reset_state_a: assert property (disable iff (1'b0) reset |=> lowest_level == 3'h7
      && in_service_bits == 8'h00) else $error("reset state wrong");
   mask_load_a: assert property (mask_write |=> channel_mask == $past(mask_wdata))
      else $error("mask not loaded");
   latch_follow_a: assert property (!irq_acknowledge_cycle |=>
      request_latch == $past(request_in)) else $error("latch lost request");
   gate_out_a: assert property (int_req |-> |(request_latch & ~channel_mask))
      else $error("masked request raised");
   prio_set_a: assert property (cmd_is(iprm_pkg::CMD_SET_PRIO) |=>
      lowest_level == $past(cmd.level)) else $error("set priority wrong");
   rot_spec_a: assert property (cmd_is(iprm_pkg::CMD_ROT_SP_DONE) |=>
      lowest_level == $past(cmd.level) && in_service_bits[$past(cmd.level)] == 1'b0)
      else $error("specific rotate wrong");
   rot_ns_a: assert property (cmd_is(iprm_pkg::CMD_ROT_NS_DONE) ##0 $onehot(in_service_bits)
      |=> in_service_bits == 8'h00 && $past(in_service_bits) == (8'h01 << lowest_level))
      else $error("rotate done wrong");
   ns_keep_a: assert property (cmd_is(iprm_pkg::CMD_NS_DONE) |=> $stable(lowest_level))
      else $error("order moved");
   smm_on_a: assert property (cmd_is(iprm_pkg::CMD_SMM_SET) |=> special_mask)
      else $error("special mask not set");
   smm_hold_a: assert property (special_mask && !(cmd_valid &&
      cmd.code == iprm_pkg::CMD_SMM_CLR) |=> special_mask) else $error("special mask lost");
   nested_block_a: assert property (!special_mask
      && in_service_bits[3'(lowest_level + 3'h1)] |-> !int_req)
      else $error("lower level not held");
endmodule
bind iprm_bank iprm_bank_properties chk (.sys_clk(sys_clk), .reset(reset),
   .request_in(request_in), .cmd_valid(cmd_valid), .cmd(cmd), .mask_write(mask_write),
   .mask_wdata(mask_wdata), .irq_acknowledge_cycle(irq_acknowledge_cycle),
   .channel_mask(channel_mask), .request_latch(request_latch),
   .in_service_bits(in_service_bits), .lowest_level(lowest_level),
   .special_mask(special_mask), .int_req(int_req));

// File: iprm_host.sv
`timescale 1ns/1ps
module iprm_host (
   input wire logic sys_clk,              // Clock
   output logic [7:0] request_in,         // Request levels
   output logic cmd_valid,                // Command strobe
   output iprm_pkg::iprm_cmd_s cmd,       // Command
   output logic mask_write,               // Mask strobe
   output logic [7:0] mask_wdata,         // Mask data
   output logic irq_acknowledge_cycle     // Ack strobe
);
   // ------------------------------------------------------------
   // Host side, all changes on the falling edge
   // ------------------------------------------------------------
   initial begin
      request_in = 8'h00;
      cmd_valid = 1'b0;
      cmd = 7'h00;
      mask_write = 1'b0;
      mask_wdata = 8'h00;
      irq_acknowledge_cycle = 1'b0;
   end
   task automatic set_req(input logic [7:0] v);
      @(negedge sys_clk);
      request_in = v;
      @(negedge sys_clk);
   endtask
   // Released fields invert so stale values never look valid
   task automatic issue(input logic [3:0] code, input logic [2:0] level);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd = {code, level};
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      cmd = ~cmd;
   endtask
   task automatic write_mask(input logic [7:0] v);
      @(negedge sys_clk);
      mask_write = 1'b1;
      mask_wdata = v;
      @(negedge sys_clk);
      mask_write = 1'b0;
      mask_wdata = ~v;
   endtask
   // One strobe, high from one falling edge to the next
   task automatic ack();
      @(negedge sys_clk);
      irq_acknowledge_cycle = 1'b1;
      @(negedge sys_clk);
      irq_acknowledge_cycle = 1'b0;
   endtask
   // Mask the level in service before entering special mask mode
   task automatic smm_enter(input logic [7:0] m);
      write_mask(m);
      issue(iprm_pkg::CMD_SMM_SET, 3'h0);
   endtask
endmodule

// File: iprm_bank_tb.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module iprm_bank_tb;
   logic sys_clk;
   logic reset;
   // Nets between host model and design, driven only by instance outputs
   wire logic [7:0] request_in, mask_wdata, channel_mask, request_latch, in_service_bits;
   wire logic cmd_valid, mask_write, irq_acknowledge_cycle, special_mask, auto_service_done;
   wire logic rotate_auto, int_req;
   wire logic [2:0] lowest_level;
   wire iprm_pkg::iprm_cmd_s cmd;
   wire iprm_pkg::iprm_ack_s ack_data;
   int err_count = 0;
   int total_checks = 0;
   initial sys_clk = 1'b0;
   always #5 sys_clk = ~sys_clk;
   iprm_host HOST (.sys_clk(sys_clk), .request_in(request_in), .cmd_valid(cmd_valid),
      .cmd(cmd), .mask_write(mask_write), .mask_wdata(mask_wdata),
      .irq_acknowledge_cycle(irq_acknowledge_cycle));
   iprm_bank DUT (.sys_clk(sys_clk), .reset(reset), .request_in(request_in),
      .cmd_valid(cmd_valid), .cmd(cmd), .mask_write(mask_write), .mask_wdata(mask_wdata),
      .irq_acknowledge_cycle(irq_acknowledge_cycle), .channel_mask(channel_mask),
      .request_latch(request_latch), .in_service_bits(in_service_bits),
      .lowest_level(lowest_level), .special_mask(special_mask),
      .auto_service_done(auto_service_done), .rotate_auto(rotate_auto), .int_req(int_req),
      .ack_data(ack_data));
   // ------------------------------------------------------------
   // Verdict and watchdog
   // ------------------------------------------------------------
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Whole run is about a hundred cycles; this margin is ample
   initial begin
      #20000;
      err_count++;
      complete_run();
   end
   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      reset = 1'b1;
      repeat (2) @(negedge sys_clk);
      reset = 1'b0;
      `CHECK({lowest_level, in_service_bits, channel_mask}, 19'h70000)
      `CHECK({special_mask, rotate_auto, auto_service_done}, 3'h0)
      HOST.set_req(8'h50);
      HOST.ack();
      `CHECK({ack_data, in_service_bits}, 12'h410)
      HOST.ack();
      HOST.set_req(8'h40);
      `CHECK(int_req, 1'b0)
      HOST.issue(iprm_pkg::CMD_ROT_NS_DONE, 3'h0);
      `CHECK({lowest_level, in_service_bits}, 11'h400)
      HOST.set_req(8'h41);
      HOST.ack();
      `CHECK(ack_data, 4'h6)
      HOST.ack();
      HOST.issue(iprm_pkg::CMD_NS_DONE, 3'h0);
      `CHECK({lowest_level, in_service_bits}, 11'h400)
      $display("test rotate non-specific done");
      HOST.set_req(8'h09);
      HOST.issue(iprm_pkg::CMD_SET_PRIO, 3'h2);
      `CHECK(lowest_level, 3'h2)
      HOST.ack();
      `CHECK(ack_data, 4'h3)
      HOST.ack();
      HOST.issue(iprm_pkg::CMD_ROT_SP_DONE, 3'h3);
      `CHECK({lowest_level, in_service_bits}, 11'h300)
      $display("test specific rotation");
      HOST.set_req(8'h11);
      HOST.issue(iprm_pkg::CMD_ROT_AUTO_SET, 3'h0);
      `CHECK(rotate_auto, 1'b1)
      HOST.ack();
      `CHECK(ack_data, 4'h4)
      HOST.ack();
      `CHECK({lowest_level, in_service_bits}, 11'h400)
      HOST.ack();
      `CHECK(ack_data, 4'h0)
      HOST.ack();
      `CHECK({lowest_level, in_service_bits}, 11'h000)
      HOST.issue(iprm_pkg::CMD_ROT_AUTO_CLR, 3'h0);
      `CHECK(rotate_auto, 1'b0)
      HOST.set_req(8'h04);
      HOST.issue(iprm_pkg::CMD_AUTO_SET, 3'h0);
      `CHECK(auto_service_done, 1'b1)
      HOST.ack();
      `CHECK(in_service_bits, 8'h04)
      HOST.ack();
      `CHECK({lowest_level, in_service_bits}, 11'h000)
      HOST.issue(iprm_pkg::CMD_AUTO_CLR, 3'h0);
      $display("test automatic modes");
      HOST.issue(iprm_pkg::CMD_SET_PRIO, 3'h7);
      HOST.write_mask(8'h01);
      HOST.set_req(8'h01);
      `CHECK({request_latch, int_req}, 9'h002)
      HOST.set_req(8'h03);
      HOST.ack();
      `CHECK(ack_data, 4'h1)
      HOST.ack();
      HOST.issue(iprm_pkg::CMD_NS_DONE, 3'h0);
      HOST.set_req(8'h01);
      HOST.write_mask(8'h00);
      `CHECK(int_req, 1'b1)
      HOST.write_mask(8'h01);
      HOST.set_req(8'h00);
      HOST.ack();
      `CHECK({ack_data, in_service_bits}, 12'hf00)
      HOST.ack();
      $display("test masking");
      HOST.write_mask(8'h00);
      HOST.set_req(8'h02);
      HOST.ack();
      HOST.ack();
      HOST.set_req(8'h08);
      `CHECK({in_service_bits, int_req}, 9'h004)
      HOST.smm_enter(8'h02);
      `CHECK({special_mask, int_req}, 2'h3)
      HOST.issue(iprm_pkg::CMD_NONE, 3'h0);
      `CHECK(special_mask, 1'b1)
      HOST.issue(iprm_pkg::CMD_SMM_CLR, 3'h0);
      `CHECK({special_mask, int_req}, 2'h0)
      HOST.issue(iprm_pkg::CMD_SP_DONE, 3'h1);
      `CHECK(in_service_bits, 8'h00)
      $display("test special mask");
      complete_run();
   end
endmodule
